// ### src/rate_port_defs.vh
// Functional notes
// - Device starts sampling and updating outputs by itself after reset, no host commands.
// - A high pulse on the sample done pin ends every internal sample cycle.
// - Serial link is mode 3: clock idles high, capture on second edge.
// - Device samples serial input on each rising serial clock edge.
// - Device changes serial output on each falling serial clock edge.
// - A register read takes two frames: request first, data second.
// - In the frame after a read request, the register's 16 bits shift out.
// - Request frame: read flag zero, seven address bits, eight don't-care bits.
// - Full duplex: next request may ride in the data frame, back to back.
// - Output bits appear only after a frame whose leading flag was zero.
// - Serial output is released while chip select is high.
// - Temperature at 0x02, rate low word at 0x04, rate high word at 0x06.
// - A word spans an even byte address and the next; both return the whole 16-bit word.
// - Rate high word is two's complement, zero rate encoded as 0x0000.
`ifndef RATE_PORT_DEFS_VH
`define RATE_PORT_DEFS_VH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define ADDR_TEMPERATURE 7'h02
`define ADDR_RATE_LOW 7'h04
`define ADDR_RATE_HIGH 7'h06
`define FRAME_BITS 5'h10
`define UNMAPPED_VALUE 16'h0000

// ----------------------------------------------------------------------------
// Field positions of a request frame
// ----------------------------------------------------------------------------
`define REQ_RW_BIT 15
`define REQ_ADDR_HI 14
`define REQ_ADDR_LO 8

// ----------------------------------------------------------------------------
// Sample timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 25
`define SAMPLE_PERIOD_US 488
`define SAMPLE_CYCLES ((`SAMPLE_PERIOD_US * 1000) / `CLK_PERIOD_NS)
`define DONE_PULSE_CYCLES 16'h0008
`define TEMP_RESET 16'h0C00
`define RATE_RESET 32'h0000_0000

`endif

// ### src/rate_sample_engine.v
`timescale 1ns/1ps
`include "rate_port_defs.vh"

module rate_sample_engine #(
  parameter SAMPLE_CYCLES = `SAMPLE_CYCLES
)
(
  input wire ref_clk,
  input wire rst_b,
  output reg update_ff,
  output reg [15:0] temp_ff,
  output reg [31:0] rate_ff
);

  reg [19:0] cnt_ff;
  reg [15:0] lfsr_ff;
  wire wrap;

  assign wrap = (cnt_ff == SAMPLE_CYCLES - 1);

  // Free-running sample timer; a fresh result is loaded at each wrap.
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_ff <= 20'h00000;
      update_ff <= 1'b0;
      lfsr_ff <= 16'hACE1;
      temp_ff <= `TEMP_RESET;
      rate_ff <= `RATE_RESET;
    end
    else
    begin
      update_ff <= wrap;
      if (wrap)
      begin
        cnt_ff <= 20'h00000;
        lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
        // Synthetic signed rate sample; sign-extended so zero rate is all zeros.
        rate_ff <= {{8{lfsr_ff[15]}}, lfsr_ff, 8'h00};
        temp_ff <= `TEMP_RESET + {12'h000, lfsr_ff[3:0]};
      end
      else
      begin
        cnt_ff <= cnt_ff + 20'h00001;
      end
    end
  end

endmodule // rate_sample_engine

// ### src/rate_sensor_spi_read_port.v
`timescale 1ns/1ps
`include "rate_port_defs.vh"

module rate_sensor_spi_read_port #(
  parameter SAMPLE_CYCLES = `SAMPLE_CYCLES
)
(
  input wire ref_clk,
  input wire rst_b,
  input wire sclk,
  input wire cs_b,
  input wire din,
  output reg dout_ff,
  output reg dout_oe_ff,
  output reg sample_done_pin_ff
);

  // --------------------------------------------------------------------------
  // Register selection
  // --------------------------------------------------------------------------
  // Picks a readable word by request address; each word spans two byte addresses.
  function [15:0] pick_word;
    input [6:0] addr;
    input [15:0] temp;
    input [31:0] rate;
    begin
      case ({addr[6:1], 1'b0})
        `ADDR_TEMPERATURE: pick_word = temp;
        `ADDR_RATE_LOW: pick_word = rate[15:0];
        `ADDR_RATE_HIGH: pick_word = rate[31:16];
        default: pick_word = `UNMAPPED_VALUE;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // Sample engine
  // --------------------------------------------------------------------------
  wire update;
  wire [15:0] temp_val;
  wire [31:0] rate_val;

  rate_sample_engine #(
    .SAMPLE_CYCLES(SAMPLE_CYCLES)
  ) u_engine (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .update_ff(update),
    .temp_ff(temp_val),
    .rate_ff(rate_val)
  );

  reg [15:0] pulse_cnt_ff;

  // Stretches the sample-end strobe into a short high pulse.
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pulse_cnt_ff <= 16'h0000;
      sample_done_pin_ff <= 1'b0;
    end
    else
    begin
      if (update)
      begin
        pulse_cnt_ff <= `DONE_PULSE_CYCLES;
        sample_done_pin_ff <= 1'b1;
      end
      else if (pulse_cnt_ff != 16'h0000)
      begin
        pulse_cnt_ff <= pulse_cnt_ff - 16'h0001;
        sample_done_pin_ff <= (pulse_cnt_ff != 16'h0001);
      end
      else
      begin
        sample_done_pin_ff <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  reg [2:0] sclk_sync_ff;
  reg [2:0] cs_sync_ff;
  reg [2:0] din_sync_ff;
  reg sclk_lvl_ff;
  reg cs_lvl_ff;
  reg din_lvl_ff;

  // Three stages per pin; a level counts once stages two and three agree.
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclk_sync_ff <= 3'h7;
      cs_sync_ff <= 3'h7;
      din_sync_ff <= 3'h0;
      sclk_lvl_ff <= 1'b1;
      cs_lvl_ff <= 1'b1;
      din_lvl_ff <= 1'b0;
    end
    else
    begin
      sclk_sync_ff <= {sclk_sync_ff[1:0], sclk};
      cs_sync_ff <= {cs_sync_ff[1:0], cs_b};
      din_sync_ff <= {din_sync_ff[1:0], din};
      if (sclk_sync_ff[1] == sclk_sync_ff[2])
      begin
        sclk_lvl_ff <= sclk_sync_ff[2];
      end
      if (cs_sync_ff[1] == cs_sync_ff[2])
      begin
        cs_lvl_ff <= cs_sync_ff[2];
      end
      if (din_sync_ff[1] == din_sync_ff[2])
      begin
        din_lvl_ff <= din_sync_ff[2];
      end
    end
  end

  wire sclk_stable;
  wire sclk_rise;
  wire sclk_fall;
  wire cs_active;

  // Serial clock idles high, so a frame is fall, rise per bit.
  assign sclk_stable = (sclk_sync_ff[1] == sclk_sync_ff[2]);
  assign sclk_rise = sclk_stable & sclk_sync_ff[2] & ~sclk_lvl_ff;
  assign sclk_fall = sclk_stable & ~sclk_sync_ff[2] & sclk_lvl_ff;
  assign cs_active = ~cs_lvl_ff;

  // --------------------------------------------------------------------------
  // Shift engine
  // --------------------------------------------------------------------------
  reg [15:0] rx_ff;
  reg [4:0] bit_cnt_ff;
  reg [15:0] tx_ff;
  reg pending_ff;
  reg [15:0] snap_ff;
  reg tx_en_ff;

  // Receives requests, captures a snapshot at frame end, shifts data out.
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_ff <= 16'h0000;
      bit_cnt_ff <= 5'h00;
      tx_ff <= 16'h0000;
      pending_ff <= 1'b0;
      snap_ff <= 16'h0000;
      tx_en_ff <= 1'b0;
      dout_ff <= 1'b0;
      dout_oe_ff <= 1'b0;
    end
    else
    begin
      if (!cs_active)
      begin
        bit_cnt_ff <= 5'h00;
        dout_oe_ff <= 1'b0;
        dout_ff <= 1'b0;
        tx_en_ff <= pending_ff;
        tx_ff <= snap_ff;
      end
      else
      begin
        if (sclk_fall)
        begin
          // First fall presents the MSB, later falls advance the word.
          if (bit_cnt_ff == 5'h00)
          begin
            tx_en_ff <= pending_ff;
            tx_ff <= {snap_ff[14:0], 1'b0};
            dout_ff <= pending_ff & snap_ff[15];
            dout_oe_ff <= pending_ff;
          end
          else
          begin
            dout_ff <= tx_en_ff & tx_ff[15];
            tx_ff <= {tx_ff[14:0], 1'b0};
            dout_oe_ff <= tx_en_ff;
          end
        end
        if (sclk_rise)
        begin
          rx_ff <= {rx_ff[14:0], din_lvl_ff};
          if (bit_cnt_ff == `FRAME_BITS - 5'h01)
          begin
            bit_cnt_ff <= 5'h00;
            // Frame complete: decide whether the next frame returns data.
            pending_ff <= ~rx_ff[`REQ_RW_BIT - 1];
            // Whole word latched at once so a sample update cannot tear it.
            snap_ff <= pick_word(rx_ff[`REQ_ADDR_HI - 1:`REQ_ADDR_LO - 1], temp_val, rate_val);
          end
          else
          begin
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
          end
        end
      end
    end
  end

endmodule // rate_sensor_spi_read_port

// ### tb/rate_sensor_spi_read_port_sva.sv
`timescale 1ns/1ps
// Watches the read port pins for framing, output timing and pulse rules.
module rate_port_checker #(
  parameter SAMPLE_CYCLES = 19520
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic din,
  input wire logic dout_ff,
  input wire logic dout_oe_ff,
  input wire logic sample_done_pin_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [15:0] gap_ff;
  logic seen_ff;
  // Counts cycles since the last pulse start, so the sample period can be judged.
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gap_ff <= 16'h0000;
      seen_ff <= 1'b0;
    end
    else
    begin
      gap_ff <= $rose(sample_done_pin_ff) ? 16'h0000 : gap_ff + 16'h0001;
      seen_ff <= seen_ff | $rose(sample_done_pin_ff);
    end
  end
  sequence s_done_pulse;
    sample_done_pin_ff [*8] ##1 !sample_done_pin_ff;
  endsequence
  sequence s_fall_seen;
    !$past(sclk, 3);
  endsequence
  a_done_pulse_width: assert property ($rose(sample_done_pin_ff) |-> s_done_pulse)
    else $error("sample done pulse width wrong");
  a_done_period: assert property ($rose(sample_done_pin_ff) && seen_ff |-> gap_ff == SAMPLE_CYCLES - 1)
    else $error("sample period wrong");
  a_sampling_runs: assert property (gap_ff <= SAMPLE_CYCLES + 8)
    else $error("sampling stalled");
  a_oe_off_deselect: assert property (cs_b [*6] |-> !dout_oe_ff)
    else $error("output driven while deselected");
  a_idle_low: assert property (!dout_oe_ff |-> !dout_ff)
    else $error("output not low while released");
  a_dout_on_fall: assert property ($changed(dout_ff) && !cs_b && $past(dout_oe_ff) && dout_oe_ff |->
    s_fall_seen)
    else $error("output changed away from falling edge");
  a_dout_stable_high: assert property ($rose(sclk) && !cs_b |-> ##3 $stable(dout_ff) [*3])
    else $error("output moved while clock high");
  a_oe_needs_frame: assert property ($rose(dout_oe_ff) |-> !cs_b ##0 s_fall_seen)
    else $error("output enabled outside a frame");
  a_oe_no_glitch: assert property ($fell(dout_oe_ff) |-> $past(cs_b, 3) || $past(cs_b, 4) || !$past(sclk, 3))
    else $error("output released mid frame");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_b |-> !dout_oe_ff && !sample_done_pin_ff)
    else $error("outputs active in reset");
endmodule // rate_port_checker

bind rate_sensor_spi_read_port rate_port_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_rate_port_checker (
  .ref_clk(ref_clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .din(din),
  .dout_ff(dout_ff), .dout_oe_ff(dout_oe_ff), .sample_done_pin_ff(sample_done_pin_ff));

// ### tb/spi_host_model.sv
`timescale 1ns/1ps
// Host master: mode 3, 16-bit frames, 200 ns clock period.
module spi_host_model (
  input wire logic dout_ff,
  input wire logic dout_oe_ff,
  output logic sclk,
  output logic cs_b,
  output logic din
);
  // Clock idles high, chip select idles high.
  initial
  begin
    sclk = 1'b1;
    cs_b = 1'b1;
    din = 1'b0;
  end
  // One frame; n counts the bit times in which the device drove its output.
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx, output logic [4:0] n);
    n = 5'h00;
    cs_b = 1'b0;
    #100;
    for (int i = 15; i >= 0; i--)
    begin
      sclk = 1'b0;
      din = tx[i];
      #100 sclk = 1'b1;
      // Captures on the rising edge; a released line shows the opposite level, so no stray value passes.
      rx[i] = dout_oe_ff ? dout_ff : ~dout_ff;
      n = n + {4'h0, dout_oe_ff};
      #100;
    end
    cs_b = 1'b1;
    din = ~din;
    #300;
  endtask
endmodule // spi_host_model

// ### tb/test_rate_sensor_spi_read_port.sv
`timescale 1ns/1ps
module test_rate_sensor_spi_read_port;
  logic ref_clk, rst_b;
  wire sclk, cs_b, din, dout_ff, dout_oe_ff, sample_done_pin_ff;
  int err_total = 0;
  int samples_checked = 0;
  localparam int SAMPLE_CYCLES = 2000;
  int cyc = 0;
  int first_rise = 0;
  logic [15:0] rx;
  logic [4:0] n;
  logic [15:0] req [8] = '{16'h0600, 16'h0400, 16'h0300, 16'h8600, 16'h0200, 16'h1000, 16'h0000, 16'h0600};
  logic [20:0] exp_tab [8] = '{21'h00FFFF, 21'h100000, 21'h100000, 21'h100C00,
                               21'h00FFFF, 21'h100C00, 21'h100000, 21'h100000};
  rate_sensor_spi_read_port #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_rate_sensor_spi_read_port (.ref_clk(ref_clk),
    .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .din(din), .dout_ff(dout_ff), .dout_oe_ff(dout_oe_ff),
    .sample_done_pin_ff(sample_done_pin_ff));
  spi_host_model u_spi_host_model (.dout_ff(dout_ff), .dout_oe_ff(dout_oe_ff), .sclk(sclk), .cs_b(cs_b), .din(din));
  // Compares one value and reports a difference.
  task automatic check(input string what, input logic [20:0] e, input logic [20:0] s);
    samples_checked++;
    if (s !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // System clock at 40 MHz.
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Free cycle count, used to time the sample period.
  always @(posedge ref_clk) cyc <= cyc + 1;
  // Cuts a hang short.
  initial
  begin
    repeat (6000) @(posedge ref_clk);
    err_total++;
    tally_and_finish;
  end
  // Chained reads before the first sample, then the sample pulse and a fresh read.
  initial
  begin
    rst_b = 1'b1;
    #2 rst_b = 1'b0;
    repeat (8) @(posedge ref_clk);
    #2 rst_b = 1'b1;
    repeat (8) @(posedge ref_clk);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge ref_clk);
      #2 u_spi_host_model.xfer(req[i], rx, n);
      check("chained read", exp_tab[i], {n, rx});
    end
    $display("test chained reads done");
    @(posedge sample_done_pin_ff);
    #1 first_rise = cyc;
    n = 5'h00;
    while (sample_done_pin_ff === 1'b1)
    begin
      @(posedge ref_clk);
      #1 n++;
    end
    check("done pulse", 21'h080000, {n, 16'h0000});
    @(posedge ref_clk);
    #2 u_spi_host_model.xfer(16'h0400, rx, n);
    check("stale high word", 21'h100000, {n, rx});
    @(posedge ref_clk);
    #2 u_spi_host_model.xfer(16'h0400, rx, n);
    check("rate low word", 21'h100000, {n, 8'h00, rx[7:0]});
    @(posedge sample_done_pin_ff);
    #1 check("sample period", 21'(SAMPLE_CYCLES), 21'(cyc - first_rise));
    $display("test sample pulse done");
    tally_and_finish;
  end
endmodule // test_rate_sensor_spi_read_port
